//--- diagnostic_observe_mux.sv
// diagnostic observe multiplexer: routes one internal node to the observe pin
// register layout seen by software:
//   probe_config[7] mux enable, observe pin released while clear
//   probe_config[6] level forced onto serial out in digital mode while chip select is high
//   probe_config[5] static level driven onto the pin in the static probe kind
//   probe_config[4:2] input check select: fault, select, data, clock
//   probe_config[1:0] probe kind: static, digital, analog, input check
//   probe_select[6:4] digital group code, probe_select[3:0] digital index
//   probe_select[7:0] one-hot analog node while in analog mode
//   unused group and check codes read as logic zero on the pin
// assumes registers are written by the serial front end on clk
// assumes every source and pin input is already synchronous to clk
// assumes self-test completion arrives as a one-cycle pulse
`timescale 1ns/1ns
`include "probe_mux_map.svh"
module diagnostic_observe_mux
    import probe_mux_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register writes from the serial front end
    input wire logic cfg_write,
    input wire logic [7:0] cfg_wdata,
    input wire logic sel_write,
    input wire logic [7:0] sel_wdata,
    input wire logic selftest_done,
    // register readback
    output logic [7:0] probe_config,
    output logic [7:0] probe_select,
    // monitor group digital sources
    input wire logic analog_internal_rail_uv_n,
    input wire logic bandgap_fault_a,
    input wire logic bandgap_fault_b,
    input wire logic [2:0] pump_cmp,
    input wire logic [3:0] rail_uv,
    input wire logic [3:0] rail_ov,
    input wire logic clock_loss_flag,
    // timing group digital sources
    input wire logic sys_clock_tap,
    input wire logic test_tap,
    input wire logic watchdog_tick,
    input wire logic reset_stretch_osc,
    input wire logic [3:0] time_ref,
    // pin echoes
    input wire logic fault_trigger_input,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic serial_clk,
    input wire logic serial_out_readback,
    input wire logic host_reset_out,
    // serial out data from the front end
    input wire logic serial_out_data,
    input wire logic serial_out_active,
    // observe pin: digital level and analog selector
    output logic observe_out,
    output logic observe_oe,
    output logic [7:0] analog_selector,
    output logic analog_route_en,
    // serial data out pin
    output logic serial_out,
    output logic serial_out_oe
);
    // next register and pin values
    logic [7:0] next_probe_config;
    logic [7:0] next_probe_select;
    logic next_observe_out;
    logic next_observe_oe;
    logic [7:0] next_analog_selector;
    logic next_analog_route_en;
    logic next_serial_out;
    logic next_serial_out_oe;

    // source tables, one bit per digital index
    logic [15:0] monitor_group;
    logic [15:0] timing_group;

    // decoded register fields
    probe_kind_t kind;
    logic enable;
    logic [2:0] group;
    logic [3:0] index;
    logic [2:0] check;

    // values picked by the digital and input check selectors
    logic digital_pick;
    logic check_pick;

    // config register: a self-test restore wins over a write in one cycle,
    // so software always finds the reset values after a self-test run
    always_comb begin
        next_probe_config = probe_config;
        if (selftest_done) begin
            next_probe_config = `CFG_RESET;
        end else if (cfg_write) begin
            next_probe_config = cfg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            probe_config <= `CFG_RESET;
        end else begin
            probe_config <= next_probe_config;
        end
    end

    // select register: same restore priority as the config register
    always_comb begin
        next_probe_select = probe_select;
        if (selftest_done) begin
            next_probe_select = `SEL_RESET;
        end else if (sel_write) begin
            next_probe_select = sel_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            probe_select <= `SEL_RESET;
        end else begin
            probe_select <= next_probe_select;
        end
    end

    // config fields
    assign kind = probe_kind_t'(probe_config[`CFG_KIND_MSB:`CFG_KIND_LSB]);
    assign enable = probe_config[`CFG_ENABLE_BIT];
    assign check = probe_config[`CFG_CHECK_MSB:`CFG_CHECK_LSB];

    // select fields: group code above the index
    assign group = probe_select[`SEL_GROUP_MSB:`SEL_GROUP_LSB];
    assign index = probe_select[`SEL_INDEX_MSB:`SEL_INDEX_LSB];

    // monitor group table, index 0 is logic zero
    assign monitor_group[0] = 1'b0;
    assign monitor_group[1] = analog_internal_rail_uv_n;

    // bandgap faults and charge pump comparators
    assign monitor_group[2] = bandgap_fault_a;
    assign monitor_group[3] = bandgap_fault_b;
    assign monitor_group[6:4] = pump_cmp;

    // loss of the internal system clock
    assign monitor_group[15] = clock_loss_flag;
    // uv/ov pairs per rail: prereg, can, io, core
    genvar r;
    generate
        for (r = 0; r < 4; r++) begin : g_rail
            assign monitor_group[7 + 2 * r] = ~rail_uv[r];
            assign monitor_group[8 + 2 * r] = rail_ov[r];
        end
    endgenerate

    // timing group table
    assign timing_group[0] = 1'b0;
    assign timing_group[1] = sys_clock_tap;
    assign timing_group[2] = test_tap;
    assign timing_group[3] = watchdog_tick;
    assign timing_group[4] = reset_stretch_osc;

    // 5 us, 15 us, 40 us and 2 ms time references
    assign timing_group[8:5] = time_ref;

    // pin echoes; the fault trigger shows at two indices
    assign timing_group[9] = fault_trigger_input;
    assign timing_group[10] = chip_select_n;
    assign timing_group[11] = serial_in;
    assign timing_group[12] = serial_clk;
    assign timing_group[13] = serial_out_readback;
    assign timing_group[14] = fault_trigger_input;
    assign timing_group[15] = host_reset_out;

    // digital selector value: the group code picks a table, the index an
    // entry; groups with no table here read as logic zero
    always_comb begin
        digital_pick = 1'b0;
        case (group)
            `GROUP_MONITOR: begin
                digital_pick = monitor_group[index];
            end
            `GROUP_TIMING: begin
                digital_pick = timing_group[index];
            end
            default: begin
                digital_pick = 1'b0;
            end
        endcase
    end

    // interconnect check value: one of four input pins, codes past the
    // last pin read as logic zero
    always_comb begin
        check_pick = 1'b0;
        case (check)
            `CHECK_FAULT: begin
                check_pick = fault_trigger_input;
            end
            `CHECK_SELECT: begin
                check_pick = chip_select_n;
            end
            `CHECK_DATA_IN: begin
                check_pick = serial_in;
            end
            `CHECK_SERIAL_CLK: begin
                check_pick = serial_clk;
            end
            default: begin
                check_pick = 1'b0;
            end
        endcase
    end

    // observe pin level and digital driver enable, picked by registered
    // fields; a cleared enable releases the pin whatever the kind
    always_comb begin
        next_observe_out = 1'b0;
        next_observe_oe = 1'b0;
        if (enable) begin
            case (kind)
                KIND_STATIC: begin
                    next_observe_out = probe_config[`CFG_STATIC_BIT];
                    next_observe_oe = 1'b1;
                end
                KIND_DIGITAL: begin
                    next_observe_out = digital_pick;
                    next_observe_oe = 1'b1;
                end
                KIND_ANALOG: begin
                    // digital driver off, the analog switch owns the pin
                    next_observe_out = 1'b0;
                    next_observe_oe = 1'b0;
                end
                KIND_INPUT_CHECK: begin
                    next_observe_out = check_pick;
                    next_observe_oe = 1'b1;
                end
                default: begin
                    next_observe_out = 1'b0;
                    next_observe_oe = 1'b1;
                end
            endcase
        end
    end

    // analog switch set, closed only while enabled in analog mode; the
    // selection passes through unchecked, software keeps it one-hot
    always_comb begin
        next_analog_selector = 8'h00;
        next_analog_route_en = 1'b0;
        if (enable && kind == KIND_ANALOG) begin
            next_analog_route_en = 1'b1;
            next_analog_selector = probe_select;
        end
    end

    // serial data out pin: the enabled mux keeps it driven even with chip
    // select high, so a shared bus needs outside help
    always_comb begin
        next_serial_out = serial_out_data;
        next_serial_out_oe = serial_out_active;
        if (enable) begin
            next_serial_out_oe = 1'b1;
            if (kind == KIND_DIGITAL && chip_select_n) begin
                next_serial_out = probe_config[`CFG_FORCE_BIT];
            end
        end
    end

    // observe pin registers so the pin moves only on clock edges and
    // never shows a half-updated selection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            observe_out <= 1'b0;
            observe_oe <= 1'b0;
        end else begin
            observe_out <= next_observe_out;
            observe_oe <= next_observe_oe;
        end
    end

    // analog switch registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            analog_selector <= 8'h00;
            analog_route_en <= 1'b0;
        end else begin
            analog_selector <= next_analog_selector;
            analog_route_en <= next_analog_route_en;
        end
    end

    // serial data out registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out <= next_serial_out;
            serial_out_oe <= next_serial_out_oe;
        end
    end
endmodule

//--- diagnostic_observe_mux_checker.sv
// assertions on the observe multiplexer ports
// assumes one clock clk and async active-low rstn
`timescale 1ns/1ns
module diagnostic_observe_mux_checker (
    // clock, reset and register writes
    input wire logic clk, rstn, cfg_write, sel_write, selftest_done,
    input wire logic [7:0] cfg_wdata, sel_wdata, probe_config, probe_select,
    // echoed pins
    input wire logic fault_trigger_input, chip_select_n, serial_in, serial_clk,
    // pin outputs
    input wire logic observe_out, observe_oe, analog_route_en, serial_out,
    input wire logic serial_out_oe,
    input wire logic [7:0] analog_selector
);
    logic chk_src;
    logic en;
    logic [1:0] kind;
    // input picked by the interconnect check field
    always_comb begin
        case (probe_config[4:2])
            3'h0: chk_src = fault_trigger_input;
            3'h1: chk_src = chip_select_n;
            3'h2: chk_src = serial_in;
            3'h3: chk_src = serial_clk;
            default: chk_src = 1'b0;
        endcase
    end
    assign en = probe_config[7];
    assign kind = probe_config[1:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_CFG_LOAD: assert property (cfg_write && !selftest_done |=>
        probe_config == $past(cfg_wdata)) else $error("config load wrong");
    AST_SEL_LOAD: assert property (sel_write && !selftest_done |=>
        probe_select == $past(sel_wdata)) else $error("select load wrong");
    AST_SELFTEST: assert property (selftest_done |=>
        probe_config == 8'h00 && probe_select == 8'h00) else $error("no reinit");
    AST_DISABLED: assert property (!en |=> !observe_oe)
        else $error("pin driven while disabled");
    AST_ANALOG: assert property (en && kind == 2'h2 |=>
        analog_route_en && !observe_oe && analog_selector == $past(probe_select))
        else $error("analog routing wrong");
    AST_STATIC: assert property (en && kind == 2'h0 |=> observe_oe &&
        observe_out == $past(probe_config[5])) else $error("static level wrong");
    AST_CHECK: assert property (en && kind == 2'h3 |=>
        observe_out == $past(chk_src)) else $error("input check wrong");
    AST_SDO_FORCE: assert property (en && kind == 2'h1 && chip_select_n |=>
        serial_out == $past(probe_config[6])) else $error("serial out force");
    AST_SDO_DRIVEN: assert property (en |=> serial_out_oe)
        else $error("serial out released while enabled");
endmodule
bind diagnostic_observe_mux diagnostic_observe_mux_checker i_chk (.clk, .rstn,
    .cfg_write, .sel_write, .selftest_done, .cfg_wdata, .sel_wdata,
    .probe_config, .probe_select, .fault_trigger_input, .chip_select_n,
    .serial_in, .serial_clk, .observe_out, .observe_oe, .analog_route_en,
    .serial_out, .serial_out_oe, .analog_selector);

//--- diagnostic_observe_mux_test.sv
// self-checking bench for the observe multiplexer
// assumes the design, checker and host model are compiled first
`timescale 1ns/1ns
module diagnostic_observe_mux_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_write = 1'b0;
    logic sel_write = 1'b0;
    logic selftest_done = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] sel_wdata = 8'h00;
    logic [31:0] src = 32'h0;
    logic [7:0] probe_config, probe_select, analog_selector;
    logic observe_out, observe_oe, analog_route_en;
    logic serial_out, serial_out_oe, pin_level, host_analog;
    logic front_data = 1'b0;
    logic front_active = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    // source bit per group and index; bit 7 marks an inverted source
    logic [7:0] map [32] = '{
        8'hFF, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h86,
        8'h0A, 8'h87, 8'h0B, 8'h88, 8'h0C, 8'h89, 8'h0D, 8'h0E,
        8'hFF, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h17, 8'h1C};
    always #5 clk = ~clk;
    diagnostic_observe_mux i_dut (.clk, .rstn, .cfg_write, .cfg_wdata,
        .sel_write, .sel_wdata, .selftest_done, .probe_config, .probe_select,
        .analog_internal_rail_uv_n(src[0]), .bandgap_fault_a(src[1]),
        .bandgap_fault_b(src[2]), .pump_cmp(src[5:3]), .rail_uv(src[9:6]),
        .rail_ov(src[13:10]), .clock_loss_flag(src[14]),
        .sys_clock_tap(src[15]), .test_tap(src[16]), .watchdog_tick(src[17]),
        .reset_stretch_osc(src[18]), .time_ref(src[22:19]),
        .fault_trigger_input(src[23]), .chip_select_n(src[24]),
        .serial_in(src[25]), .serial_clk(src[26]),
        .serial_out_readback(src[27]), .host_reset_out(src[28]),
        .serial_out_data(front_data), .serial_out_active(front_active),
        .observe_out,
        .observe_oe, .analog_selector, .analog_route_en, .serial_out,
        .serial_out_oe);
    observe_host i_host (.clk, .observe_out, .observe_oe, .analog_route_en,
        .pin_level, .host_analog);
    task automatic check8(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask
    // write both registers, wait until the pin reflects them
    task automatic wr(input logic [7:0] c, s);
        cfg_wdata = c;
        sel_wdata = s;
        cfg_write = 1'b1;
        sel_write = 1'b1;
        @(posedge clk) #1;
        cfg_write = 1'b0;
        sel_write = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [31:0] v);
        src = v;
        @(posedge clk) #1;
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        check1(observe_oe, 1'b0);
        for (int i = 0; i < 32; i++) begin
            wr(8'h81, {3'h0, i[4], i[3:0]});
            put(map[i] == 8'hFF ? 32'hFFFFFFFF : 32'h0);
            check1(pin_level, map[i] != 8'hFF && map[i][7]);
            if (map[i] != 8'hFF) begin
                put(32'h1 << map[i][5:0]);
                check1(pin_level, !map[i][7]);
            end
        end
        front_data = 1'b1;
        front_active = 1'b1;
        wr(8'h01, 8'h01);
        check1(observe_oe, 1'b0);
        check1(serial_out, 1'b1);
        check1(serial_out_oe, 1'b1);
        front_active = 1'b0;
        @(posedge clk) #1;
        check1(serial_out_oe, 1'b0);
        front_data = 1'b0;
        wr(8'h81, 8'h20);
        put(32'hFFFFFFFF);
        check1(observe_out, 1'b0);
        check1(serial_out, 1'b0);
        check1(serial_out_oe, 1'b1);
        wr(8'hC1, 8'h20);
        check1(serial_out, 1'b1);
        for (int k = 7; k >= 0; k--) begin
            wr(8'h82, 8'h01 << k);
            check8(analog_selector, 8'h01 << k);
            check1(analog_route_en & ~observe_oe, 1'b1);
            check1(host_analog, 1'b1);
        end
        cfg_wdata = 8'hFF;
        cfg_write = 1'b1;
        selftest_done = 1'b1;
        @(posedge clk) #1;
        cfg_write = 1'b0;
        selftest_done = 1'b0;
        @(posedge clk) #1;
        check8(probe_config, 8'h00);
        check8(probe_select, 8'h00);
        wr(8'hA0, 8'h00);
        check1(pin_level, 1'b1);
        wr(8'h80, 8'h00);
        check1(pin_level, 1'b0);
        for (int k = 0; k < 5; k++) begin
            put(32'h1 << (23 + k));
            wr(8'h83 | 8'(k << 2), 8'h00);
            check1(pin_level, k < 4);
        end
        rstn = 1'b0;
        @(posedge clk) #1;
        check8(probe_config, 8'h00);
        check1(observe_oe, 1'b0);
        rstn = 1'b1;
        @(posedge clk) #1;
        check1(observe_oe, 1'b0);
        wr(8'hA0, 8'h00);
        check1(pin_level, 1'b1);
        results();
    end
endmodule

//--- observe_host.sv
// host input pin model watching the observe pin
// assumes it is wired to the design pin outputs
`timescale 1ns/1ns
module observe_host (
    // clock and pin
    input wire logic clk,
    input wire logic observe_out,
    input wire logic observe_oe,
    input wire logic analog_route_en,
    // what the host sees
    output logic pin_level,
    output logic host_analog
);
    logic last = 1'b0;
    // remember the last driven level
    always @(posedge clk) begin
        if (observe_oe) begin
            last <= observe_out;
        end
    end
    // a released pin floats, so show the inverse of the last level
    assign pin_level = observe_oe ? observe_out : ~last;
    assign host_analog = analog_route_en;
endmodule

//--- probe_mux_map.svh
// constants for the diagnostic observe multiplexer
// assumes an including module that uses the probe_mux_pkg types
// Functional notes
// - bit 7 of probe config enables the mux; cleared means observe pin tri-stated.
// - observed signal comes only from the probe selection register value; static and input check kinds take it from probe config fields.
// - probe kind 10b is analog mode, routing the chosen analog node.
// - analog selection is one-hot, 0x01 can rail through 0x80 monitor reference.
// - probe kind 01b is digital mode, group code and index pick a signal.
// - group 000b: zero, analog rail UV, two bandgap faults, three pump comparators.
// - group 000b 0111b-1110b: UV/OV pairs for prereg, can, io, core; UV inverted.
// - group 000b index 1111b gives the clock loss flag.
// - group 001b: zero, clock, test, watchdog tick, stretch osc, four time refs.
// - group 001b 1001b-1111b echo pins; fault trigger twice; reset readback last.
// - while enabled, serial out stays driven even with chip select high.
// - probe kind 00b drives the observe pin to the static level bit.
// - probe kind 11b routes one of four inputs chosen by input check select.
// - digital mode, chip select high: serial out follows bit D6; else pin low. The code passes serial_out_data through otherwise.
// - after self-test completes both probe registers return to reset values.
`ifndef PROBE_MUX_MAP_SVH
`define PROBE_MUX_MAP_SVH
`define CFG_ENABLE_BIT 7
`define CFG_FORCE_BIT 6
`define CFG_STATIC_BIT 5
`define CFG_CHECK_MSB 4
`define CFG_CHECK_LSB 2
`define CFG_KIND_MSB 1
`define CFG_KIND_LSB 0
`define CFG_RESET 8'h00
`define SEL_RESET 8'h00
`define SEL_GROUP_MSB 6
`define SEL_GROUP_LSB 4
`define SEL_INDEX_MSB 3
`define SEL_INDEX_LSB 0
`define GROUP_MONITOR 3'h0
`define GROUP_TIMING 3'h1
`define CHECK_FAULT 3'h0
`define CHECK_SELECT 3'h1
`define CHECK_DATA_IN 3'h2
`define CHECK_SERIAL_CLK 3'h3
`endif

//--- probe_mux_pkg.sv
// types for the diagnostic observe multiplexer
// assumes nothing beyond the map header
package probe_mux_pkg;
    typedef enum logic [1:0] {
        KIND_STATIC = 2'h0,
        KIND_DIGITAL = 2'h1,
        KIND_ANALOG = 2'h2,
        KIND_INPUT_CHECK = 2'h3
    } probe_kind_t;
endpackage
